//--- edu_dispatch.sv
/*
 exception dispatch unit: classifies pipeline exceptions, software
 interrupts and hardware interrupts, picks the return address and
 forms the handler table entry address. assumes the pipeline reports
 one exception per boundary and holds its inputs until dispatch_out.
*/
`default_nettype none
`include "edu_regs.svh"
module edu_dispatch (
    input  wire logic        mclk_in,
    input  wire logic        nrst_in,
    input  wire logic        boundary_in,
    input  wire logic [31:0] insn_start_in,
    input  wire logic [31:0] next_insn_in,
    input  wire logic        exc_valid_in,
    input  wire logic [7:0]  exc_vector_in,
    input  wire logic        exc_is_trap_in,
    input  wire logic        exc_severe_in,
    input  wire logic        not_present_in,
    input  wire logic        page_access_in,
    input  wire logic        soft_int_in,
    input  wire logic [7:0]  soft_vector_in,
    input  wire logic        maskable_irq_pin_in,
    input  wire logic        nmi_pin_in,
    input  wire logic        ack_done_in,
    input  wire logic [7:0]  ack_vector_in,
    input  wire logic        handler_return_opcode_in,
    input  wire logic        prot_mode_in,
    input  wire logic [31:0] table_base_in,
    input  wire logic        if_set_in,
    input  wire logic        if_clear_in,
    output logic             ack_cycle_out,
    output logic             dispatch_out,
    output logic             inhibit_commit_out,
    output logic [7:0]       vector_out,
    output edu_pkg::edu_class_type class_out,
    output logic [31:0]      return_addr_out,
    output logic [31:0]      entry_addr_out,
    output logic [3:0]       entry_bytes_out,
    output logic             processor_vector_out,
    output logic             int_enable_out,
    output logic             nmi_busy_out
);
    // *****************************
    // state
    // *****************************
    typedef enum logic [1:0] {
        edu_idle_type,
        edu_ack_type
    } edu_state_type;
    edu_state_type state_reg, state_next;
    logic        if_reg, if_next;
    logic        saved_if_reg, saved_if_next;
    logic        nmi_busy_reg, nmi_busy_next;
    logic        nmi_pend_reg, nmi_pend_next;
    logic        nmi_prev_reg;
    logic        disp_reg;
    logic [7:0]  vec_reg, vec_next;
    edu_pkg::edu_class_type cls_reg, cls_next;
    logic [31:0] ret_reg, ret_next;
    logic [31:0] ent_reg;
    logic [3:0]  ent_bytes_reg;
    logic        fire;
    edu_entry_if ent ();
    edu_entry_calc u_calc (.ent(ent));

    // *****************************
    // request decode
    // *****************************
    wire nmi_rise = nmi_pin_in & ~nmi_prev_reg;
    wire nmi_req = (nmi_rise | nmi_pend_reg) & ~nmi_busy_reg;
    wire irq_req = maskable_irq_pin_in & if_reg;
    wire idle = (state_reg == edu_idle_type);
    // faults must come before commit; the pipeline holds state meanwhile
    wire np_fault = not_present_in;
    wire exc_req = idle & (exc_valid_in | np_fault | soft_int_in);
    wire hw_ok = idle & boundary_in & ~exc_req;
    wire take_nmi = hw_ok & nmi_req;
    wire take_irq = hw_ok & ~nmi_req & irq_req;
    wire take_ack = (state_reg == edu_ack_type) & ack_done_in;
    wire [7:0] np_vec = page_access_in ? `EDU_PF_VECTOR : `EDU_NP_VECTOR;
    wire [7:0] exc_vec = exc_severe_in ? `EDU_ABORT_VECTOR :
                         np_fault ? np_vec :
                         exc_valid_in ? exc_vector_in : soft_vector_in;

    assign ent.vector = vec_next;
    assign ent.prot_mode = prot_mode_in;
    assign ent.table_base = table_base_in;

    always_comb begin
        state_next = state_reg;
        if_next = if_reg;
        saved_if_next = saved_if_reg;
        nmi_busy_next = nmi_busy_reg;
        nmi_pend_next = nmi_pend_reg | (nmi_rise & nmi_busy_reg);
        vec_next = vec_reg;
        cls_next = cls_reg;
        ret_next = ret_reg;
        fire = 1'b0;
        if (if_clear_in) begin
            if_next = 1'b0;
        end
        if (if_set_in) begin
            if_next = 1'b1;
        end
        case (state_reg)
            edu_idle_type: begin
                if (exc_req) begin
                    fire = 1'b1;
                    vec_next = exc_vec;
                    if (exc_severe_in) begin
                        cls_next = edu_pkg::edu_cls_abort_type;
                        ret_next = insn_start_in;
                    end else if (np_fault | (exc_valid_in & ~exc_is_trap_in)) begin
                        cls_next = edu_pkg::edu_cls_fault_type;
                        ret_next = insn_start_in;
                    end else begin
                        cls_next = edu_pkg::edu_cls_trap_type;
                        ret_next = next_insn_in;
                    end
                end else if (take_nmi) begin
                    fire = 1'b1;
                    vec_next = `EDU_NMI_VECTOR;
                    cls_next = edu_pkg::edu_cls_int_type;
                    ret_next = next_insn_in;
                    nmi_busy_next = 1'b1;
                    nmi_pend_next = 1'b0;
                end else if (take_irq) begin
                    state_next = edu_ack_type;
                    cls_next = edu_pkg::edu_cls_int_type;
                    ret_next = next_insn_in;
                end else if (handler_return_opcode_in) begin
                    if_next = saved_if_reg;
                    nmi_busy_next = 1'b0;
                end
            end
            edu_ack_type: begin
                if (take_ack) begin
                    fire = 1'b1;
                    vec_next = ack_vector_in;
                    state_next = edu_idle_type;
                end
            end
            default: begin
                state_next = edu_idle_type;
            end
        endcase
        if (fire) begin
            saved_if_next = if_reg;
            if_next = 1'b0;
        end
    end

    // *****************************
    // registers
    // *****************************
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            state_reg <= edu_idle_type;
            if_reg <= `EDU_RESET_IF;
            saved_if_reg <= `EDU_RESET_IF;
            nmi_busy_reg <= 1'b0;
            nmi_pend_reg <= 1'b0;
            nmi_prev_reg <= 1'b0;
            disp_reg <= 1'b0;
            vec_reg <= 8'h00;
            cls_reg <= edu_pkg::edu_cls_int_type;
            ret_reg <= 32'h00000000;
            ent_reg <= 32'h00000000;
            ent_bytes_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            if_reg <= if_next;
            saved_if_reg <= saved_if_next;
            nmi_busy_reg <= nmi_busy_next;
            nmi_pend_reg <= nmi_pend_next;
            nmi_prev_reg <= nmi_pin_in;
            disp_reg <= fire;
            vec_reg <= vec_next;
            cls_reg <= cls_next;
            ret_reg <= ret_next;
            if (fire) begin
                ent_reg <= ent.entry_addr;
                ent_bytes_reg <= ent.entry_bytes;
            end
        end
    end

    // *****************************
    // outputs
    // *****************************
    // commit is blocked combinationally so a fault never retires its insn
    // soft ints and traps retire their insn, only faults and aborts block
    assign inhibit_commit_out = exc_req & (exc_severe_in | np_fault |
        (exc_valid_in & ~exc_is_trap_in));
    assign ack_cycle_out = (state_reg == edu_ack_type);
    assign dispatch_out = disp_reg;
    assign vector_out = vec_reg;
    assign class_out = cls_reg;
    assign return_addr_out = ret_reg;
    assign entry_addr_out = ent_reg;
    assign entry_bytes_out = ent_bytes_reg;
    assign processor_vector_out = (vec_reg <= `EDU_RESERVED_TOP);
    assign int_enable_out = if_reg;
    assign nmi_busy_out = nmi_busy_reg;
endmodule : edu_dispatch
`default_nettype wire

//--- edu_dispatch_props.sv
/* concurrent checks on the dispatch unit's top ports.
   assumes a bind onto edu_dispatch; one clock, low reset. */
`default_nettype none
module edu_props (
    input wire logic        mclk_in, nrst_in, boundary_in, exc_valid_in,
    input wire logic        exc_is_trap_in, ack_done_in, prot_mode_in,
    input wire logic        ack_cycle_out, dispatch_out, inhibit_commit_out,
    input wire logic        processor_vector_out, int_enable_out,
    input wire logic [7:0]  ack_vector_in, vector_out,
    input wire logic [3:0]  entry_bytes_out,
    input wire logic [31:0] insn_start_in, next_insn_in, table_base_in,
    input wire logic [31:0] return_addr_out, entry_addr_out,
    input wire edu_pkg::edu_class_type class_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    sequence ack_end_s; ack_cycle_out && ack_done_in; endsequence
    sequence fault_req_s;
        exc_valid_in && !exc_is_trap_in && !ack_cycle_out && !dispatch_out;
    endsequence
    // faults and aborts restart at the start byte, all else at the next
    wire logic hard_w = class_out == edu_pkg::edu_cls_fault_type ||
        class_out == edu_pkg::edu_cls_abort_type;
    proc_vec_a: assert property (
        dispatch_out |-> processor_vector_out == (vector_out <= 8'h1f))
        else $error("processor vector flag wrong");
    entry_addr_a: assert property (dispatch_out |->
        entry_addr_out == table_base_in + ({24'h0, vector_out} <<
        (prot_mode_in ? 3 : 2)) && entry_bytes_out ==
        (prot_mode_in ? 4'h8 : 4'h4)) else $error("table entry wrong");
    ret_addr_a: assert property (dispatch_out |->
        return_addr_out == (hard_w ? insn_start_in : next_insn_in))
        else $error("return address wrong");
    if_clear_a: assert property (dispatch_out |-> !int_enable_out)
        else $error("enable flag kept at dispatch");
    ack_seq_a: assert property (ack_end_s |=> dispatch_out &&
        !ack_cycle_out && vector_out == $past(ack_vector_in))
        else $error("acknowledge vector not dispatched");
    irq_bound_a: assert property (
        $rose(ack_cycle_out) |-> $past(boundary_in))
        else $error("interrupt taken off a boundary");
    fault_inh_a: assert property (
        fault_req_s |-> inhibit_commit_out ##1 dispatch_out && hard_w)
        else $error("fault not held back");
    abort_vec_a: assert property (dispatch_out &&
        class_out == edu_pkg::edu_cls_abort_type |-> vector_out == 8'h08)
        else $error("abort vector wrong");
endmodule : edu_props
`default_nettype wire

//--- edu_dispatch_tb_top.sv
/* bench for edu_dispatch with a stand-in interrupt controller.
   assumes edu_props and edu_pic_model are compiled before it. */
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module edu_dispatch_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, bnd = 0, ev = 0, tr = 0, sev = 0, np = 0;
    logic pg = 0, si = 0, irq = 0, nmi = 0, ret = 0, pm = 0, ifs = 0;
    logic ifc = 0, ackd, ackc, disp, inh, pv, ie, hit, nb;
    logic [7:0] xv = 0, av, vo, pvec = 8'h20;
    logic [3:0] lat = 0, eb;
    logic [31:0] st = 0, nx = 0, base = 0, ra, ea;
    // kinds: fault, trap, soft, abort, segment, page
    logic [5:0] kt [6] = '{6'h20, 6'h30, 6'h04, 6'h28, 6'h02, 6'h03};
    logic [7:0] vt [6] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h0b, 8'h0e};
    logic [1:0] ct [6] = '{2'd1, 2'd2, 2'd2, 2'd3, 2'd1, 2'd1};
    edu_pkg::edu_class_type cls;
    int n_fail = 0, checks = 0, cyc = 0;
    edu_dispatch uut (.mclk_in(clk), .nrst_in(rst_n), .boundary_in(bnd),
        .insn_start_in(st), .next_insn_in(nx), .exc_valid_in(ev),
        .exc_vector_in(xv), .exc_is_trap_in(tr), .exc_severe_in(sev),
        .not_present_in(np), .page_access_in(pg), .soft_int_in(si),
        .soft_vector_in(xv), .maskable_irq_pin_in(irq), .nmi_pin_in(nmi),
        .ack_done_in(ackd), .ack_vector_in(av), .prot_mode_in(pm),
        .handler_return_opcode_in(ret), .table_base_in(base),
        .if_set_in(ifs), .if_clear_in(ifc), .ack_cycle_out(ackc),
        .dispatch_out(disp), .inhibit_commit_out(inh), .vector_out(vo),
        .class_out(cls), .return_addr_out(ra), .entry_addr_out(ea),
        .entry_bytes_out(eb), .processor_vector_out(pv),
        .int_enable_out(ie), .nmi_busy_out(nb));
    edu_pic_model pic (.clk_in(clk), .ack_cycle_in(ackc), .lat_in(lat),
        .vec_in(pvec), .done_out(ackd), .vec_out(av));
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (++cyc > 2000) begin
        n_fail++;
        summarize();
    end
    function automatic logic [31:0] ent(input logic [7:0] v);
        return base + ({24'h0, v} << (pm ? 3 : 2));
    endfunction : ent
    task automatic chk(input logic [7:0] v, input logic [1:0] c,
                       input logic [31:0] r);
        `CHK(disp, 1'b1)
        `CHK(vo, v)
        `CHK(cls, c)
        `CHK(ra, r)
        `CHK(ea, ent(v))
        `CHK(eb, pm ? 4'h8 : 4'h4)
        `CHK(pv, v < 8'h20)
    endtask : chk
    task automatic summarize();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    initial begin
        void'($urandom(32'ha17b81ed));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 36; i++) begin
            @(posedge clk);
            {st, nx, base} <= {$urandom, $urandom, $urandom};
            {xv, pm} <= 9'($urandom);
            {ev, tr, sev, si, np, pg} <= kt[i % 6];
            @(negedge clk);
            `CHK(inh, i % 6 == 0 || i % 6 > 2)
            @(posedge clk);
            {ev, tr, sev, si, np, pg} <= 6'h00;
            @(negedge clk);
            chk(i % 6 < 3 ? xv : vt[i % 6], ct[i % 6],
                i % 6 == 1 || i % 6 == 2 ? nx : st);
        end
        @(posedge clk);
        ifs <= 1'b1;
        // slow and prompt controller answers
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            {ifs, irq, bnd, lat} <= {3'b011, 4'(i * 4)};
            pvec <= 8'h20 + 8'($urandom_range(223));
            @(posedge clk);
            {irq, bnd} <= 2'b00;
            @(negedge clk);
            `CHK(ackc, 1'b1)
            for (int j = 0; j < 20 && disp !== 1'b1; j++) @(negedge clk);
            chk(pvec, 2'd0, nx);
            @(posedge clk);
            ret <= 1'b1;
            @(posedge clk);
            ret <= 1'b0;
            @(negedge clk);
            `CHK(ie, 1'b1)
        end
        @(posedge clk);
        {ifc, irq, hit} <= 3'b110;
        @(posedge clk);
        {ifc, bnd} <= 2'b01;
        repeat (4) @(negedge clk) hit = hit | ackc | disp;
        `CHK(hit, 1'b0)
        @(posedge clk);
        {ifs, bnd} <= 2'b10;
        @(posedge clk);
        {ifs, nmi, bnd} <= 3'b011;
        for (int j = 0; j < 20 && disp !== 1'b1; j++) @(negedge clk);
        chk(8'h02, 2'd0, nx);
        `CHK(ackc, 1'b0)
        `CHK(nb, 1'b1)
        @(posedge clk);
        {ret, irq, bnd} <= 3'b100;
        @(posedge clk);
        ret <= 1'b0;
        @(negedge clk);
        `CHK(nb, 1'b0)
        `CHK(ie, 1'b1)
        summarize();
    end
endmodule : edu_dispatch_tb_top
bind edu_dispatch edu_props chk_i (.*);
`default_nettype wire

//--- edu_entry_calc.sv
/*
 forms the handler table entry address and its size from the vector.
 assumes a stable request while the dispatcher samples the answer.
*/
`default_nettype none
`include "edu_regs.svh"
module edu_entry_calc (
    edu_entry_if.calc ent
);
    // *****************************
    // address arithmetic
    // *****************************
    wire [31:0] vec_ext = {24'h000000, ent.vector};
    wire [31:0] off_real = vec_ext << `EDU_REAL_ENTRY_SH;
    wire [31:0] off_prot = vec_ext << `EDU_PROT_ENTRY_SH;
    // wraps at 4 GB, as the linear address does
    assign ent.entry_addr = ent.table_base +
        (ent.prot_mode ? off_prot : off_real);
    assign ent.entry_bytes = ent.prot_mode ? `EDU_PROT_ENTRY_RD
                                           : `EDU_REAL_ENTRY_RD;
endmodule : edu_entry_calc
`default_nettype wire

//--- edu_entry_if.sv
/*
 carries the vector-to-table-entry request between the dispatcher and
 the address former. assumes one clock domain.
*/
`default_nettype none
interface edu_entry_if;
    logic [7:0]  vector;
    logic        prot_mode;
    logic [31:0] table_base;
    logic [31:0] entry_addr;
    logic [3:0]  entry_bytes;
    modport req (output vector, output prot_mode, output table_base,
                 input entry_addr, input entry_bytes);
    modport calc (input vector, input prot_mode, input table_base,
                  output entry_addr, output entry_bytes);
endinterface : edu_entry_if
`default_nettype wire

//--- edu_pic_model.sv
/* stand-in interrupt controller: answers the acknowledge cycle.
   assumes ack_cycle_in stays high until done_out is seen. */
`default_nettype none
module edu_pic_model (
    input  wire logic       clk_in, ack_cycle_in,
    input  wire logic [3:0] lat_in,
    input  wire logic [7:0] vec_in,
    output logic            done_out,
    output logic      [7:0] vec_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_reg = 4'h0;
    logic       done_reg = 1'b0;
    assign done_out = done_reg;
    // released vector bus must not look valid: show the inverse
    assign vec_out = done_reg ? vec_in : ~vec_in;
    always @(posedge clk_in) begin
        done_reg <= ack_cycle_in && !done_reg && cnt_reg == lat_in;
        cnt_reg <= ack_cycle_in && !done_reg ? cnt_reg + 4'h1 : 4'h0;
    end
endmodule : edu_pic_model
`default_nettype wire

//--- edu_pkg.sv
/*
 types shared by the exception dispatch unit modules.
 assumes nothing beyond a standard compiler.
*/
`default_nettype none
package edu_pkg;
    typedef enum logic [1:0] {
        edu_cls_int_type,
        edu_cls_fault_type,
        edu_cls_trap_type,
        edu_cls_abort_type
    } edu_class_type;
    typedef enum logic [1:0] {
        edu_src_none_type,
        edu_src_nmi_type,
        edu_src_irq_type,
        edu_src_exc_type
    } edu_src_type;
endpackage : edu_pkg
`default_nettype wire

//--- edu_regs.svh
/*
 holds the constants of the exception dispatch unit: vectors, entry sizes,
 entry shifts and the reset enable flag. assumes it is included by bare name after the package.
*/
`ifndef EDU_REGS_SVH
`define EDU_REGS_SVH
`define EDU_NMI_VECTOR      8'h02
`define EDU_ABORT_VECTOR    8'h08
`define EDU_NP_VECTOR       8'h0b
`define EDU_PF_VECTOR       8'h0e
`define EDU_RESERVED_TOP    8'h1f
`define EDU_REAL_ENTRY_SH   2
`define EDU_PROT_ENTRY_SH   3
`define EDU_REAL_ENTRY_RD   4'h4
`define EDU_PROT_ENTRY_RD   4'h8
`define EDU_RESET_IF        1'b0
`endif
